// ==== common/nnao_defs.svh ====
`ifndef NNAO_DEFS_SVH
`define NNAO_DEFS_SVH

// ********************************************************
// register byte offsets
// ********************************************************
`define NNAO_OFF_CMD      8'h00
`define NNAO_OFF_ACC      8'h04
`define NNAO_OFF_PROD     8'h08
`define NNAO_OFF_STAT     8'h0c
`define NNAO_OFF_PSEL     8'h10
`define NNAO_OFF_RCNT     8'h14
`define NNAO_PTR_WIN      3'b001

// ********************************************************
// status field positions
// ********************************************************
`define NNAO_ST_N         0
`define NNAO_ST_Z         1
`define NNAO_ST_C         2
`define NNAO_ST_V         3
`define NNAO_ST_TEST      4
`define NNAO_ST_SAT       5

// ********************************************************
// widths, limits and counts
// ********************************************************
`define NNAO_RCNT_W       8
`define NNAO_MIN16        16'h8000
`define NNAO_MIN32        32'h8000_0000
`define NNAO_MAX32        32'h7fff_ffff
`define NNAO_MIN64        64'h8000_0000_0000_0000
`define NNAO_MAX64        64'h7fff_ffff_ffff_ffff
`define NNAO_NORMALIZE_OP_TAIL    2'h3
`define NNAO_RST_WORD     32'h0000_0000

`endif

// ==== common/nnao_pkg.sv ====
`default_nettype none
`include "nnao_defs.svh"

package nnao_pkg;

	typedef enum logic [1:0] {NNAO_IDLE, NNAO_EXEC, NNAO_TAIL} nnao_fsm_t;

	typedef enum logic [2:0] {
		NNAO_K_NONE,
		NNAO_K_NEGH,
		NNAO_K_WIDENEG,
		NNAO_K_CONDNEG,
		NNAO_K_NOP,
		NNAO_K_NORMALIZE_OP
	} nnao_kind_t;

	typedef enum logic [2:0] {
		NNAO_PM_NONE,
		NNAO_PM_INC,
		NNAO_PM_DEC,
		NNAO_PM_ADD0,
		NNAO_PM_SUB0
	} nnao_pmode_t;

	typedef struct packed {
		nnao_fsm_t                 fsm;
		nnao_kind_t                kind;
		logic [15:0]               op;
		logic [`NNAO_RCNT_W-1:0]   iter;
		logic [1:0]                tail;
		logic                      busy;
		logic [31:0]               acc;
		logic [31:0]               prod;
		logic                      n;
		logic                      z;
		logic                      c;
		logic                      v;
		logic                      test_condition_flag;
		logic                      saturation_mode_bit;
		logic [2:0]                pointer_select_reg;
		logic [`NNAO_RCNT_W-1:0]   repeat_count_reg;
		logic [7:0][31:0]          auxiliary_pointers;
		logic [31:0]               prdata;
		logic                      pready;
		logic                      pslverr;
	} nnao_state_t;

endpackage

`default_nettype wire

// ==== common/nnao_ptr_if.sv ====
`timescale 1ns/1ns
`default_nettype none

interface nnao_ptr_if;
	logic [31:0]          cur;
	logic [31:0]          ar0;
	nnao_pkg::nnao_pmode_t mode;
	logic [31:0]          nxt;

	modport core (output cur, output ar0, output mode, input nxt);
	modport unit (input cur, input ar0, input mode, output nxt);
endinterface

`default_nettype wire

// ==== logic/nnao_ptr_step.sv ====
`timescale 1ns/1ns
`default_nettype none

// ********************************************************
// pointer step: arithmetic only, never an address
// ********************************************************
module nnao_ptr_step
(
	// pointer link
	nnao_ptr_if.unit ptr
);

	always_comb
	begin
		case (ptr.mode)
			nnao_pkg::NNAO_PM_INC:  ptr.nxt = ptr.cur + 32'h0000_0001;
			nnao_pkg::NNAO_PM_DEC:  ptr.nxt = ptr.cur - 32'h0000_0001;
			nnao_pkg::NNAO_PM_ADD0: ptr.nxt = ptr.cur + ptr.ar0;
			nnao_pkg::NNAO_PM_SUB0: ptr.nxt = ptr.cur - ptr.ar0;
			default:                ptr.nxt = ptr.cur;
		endcase
	end

endmodule // nnao_ptr_step

`default_nettype wire

// ==== logic/nnao_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "nnao_defs.svh"

// Contract
// - half negate: negative from result bit 15, zero when result zero
// - half negate: carry set when result zero, else cleared
// - half negate: overflow set if start 0x8000, else untouched
// - half negate not repeatable: clear repeat count, run once
// - wide negate negates accumulator:product as one 64-bit value
// - wide negate: negative from accumulator bit 31
// - wide negate: zero only when whole 64-bit result zero
// - wide negate: carry set when 64-bit result zero, else cleared
// - wide negate of most negative: overflow, saturate or keep
// - conditional negate acts only when test flag is one
// - conditional negate of 0x80000000: overflow, saturate or keep
// - conditional negate carry: set/clear when test set, else kept
// - conditional negate: negative from bit 31, zero if accumulator zero
// - idle op applies pointer step and switches pointer select
// - idle op repeatable, runs count plus one times
// - indirect normalize steps the selected pointer, takes count plus four
// - normalize shifts and steps pointer only when bits 31,30 equal
// - normalize pointer update is arithmetic only, no memory access
// - normalize test flag set if no shift or zero, cleared on shift
// - normalize repeatable, flags show final iteration only
// - half negate is two's complement, 0x8000 stays 0x8000

module nnao_top
(
	// clock, reset, enable
	input  wire logic        REF_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        CLK_EN,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// status
	output logic             BUSY
);

	// ********************************************************
	// state and working signals
	// ********************************************************
	nnao_pkg::nnao_state_t st;
	nnao_pkg::nnao_state_t nx;
	nnao_ptr_if            ptr ();
	logic [2:0]            sel;
	logic [15:0]           half;
	logic [15:0]           half_res;
	logic [63:0]           wide_res;
	logic [31:0]           acc_res;
	logic [31:0]           rd_word;
	logic                  rd_ok;
	logic                  access;
	nnao_pkg::nnao_kind_t  new_kind;

	nnao_ptr_step u_ptr
	(
		.ptr (ptr)
	);

	// ********************************************************
	// opcode decode
	// ********************************************************
	function automatic nnao_pkg::nnao_kind_t kind_of(input logic [15:0] op);
		casez (op)
			16'b1111_1111_0101_110?: kind_of = nnao_pkg::NNAO_K_NEGH;
			16'h5658:                kind_of = nnao_pkg::NNAO_K_WIDENEG;
			16'h5632:                kind_of = nnao_pkg::NNAO_K_CONDNEG;
			16'b0111_0111_????_????: kind_of = nnao_pkg::NNAO_K_NOP;
			16'h5624, 16'h565a, 16'h5620,
			16'h5677, 16'h5630:      kind_of = nnao_pkg::NNAO_K_NORMALIZE_OP;
			16'b1111_1111_0111_????: kind_of = nnao_pkg::NNAO_K_NORMALIZE_OP;
			default:                 kind_of = nnao_pkg::NNAO_K_NONE;
		endcase
	endfunction

	function automatic nnao_pkg::nnao_pmode_t pmode_of(input logic [15:0] op);
		casez (op)
			16'b0111_0111_01??_????: pmode_of = nnao_pkg::NNAO_PM_INC;
			16'b0111_0111_10??_????: pmode_of = nnao_pkg::NNAO_PM_DEC;
			16'h565a:                pmode_of = nnao_pkg::NNAO_PM_INC;
			16'h5620:                pmode_of = nnao_pkg::NNAO_PM_DEC;
			16'h5677:                pmode_of = nnao_pkg::NNAO_PM_ADD0;
			16'h5630:                pmode_of = nnao_pkg::NNAO_PM_SUB0;
			16'b1111_1111_0111_1???: pmode_of = nnao_pkg::NNAO_PM_INC;
			16'b1111_1111_0111_0???: pmode_of = nnao_pkg::NNAO_PM_DEC;
			default:                 pmode_of = nnao_pkg::NNAO_PM_NONE;
		endcase
	endfunction

	// ********************************************************
	// read mux
	// ********************************************************
	always_comb
	begin
		rd_ok = 1'b1;
		rd_word = `NNAO_RST_WORD;
		case (PADDR)
			`NNAO_OFF_CMD:  rd_word = {16'h0000, st.op};
			`NNAO_OFF_ACC:  rd_word = st.acc;
			`NNAO_OFF_PROD: rd_word = st.prod;
			`NNAO_OFF_STAT: rd_word = {26'h0, st.saturation_mode_bit,
				st.test_condition_flag, st.v, st.c, st.z, st.n};
			`NNAO_OFF_PSEL: rd_word = {29'h0, st.pointer_select_reg};
			`NNAO_OFF_RCNT: rd_word = {24'h0, st.repeat_count_reg};
			default:
			begin
				if (PADDR[7:5] == `NNAO_PTR_WIN && PADDR[1:0] == 2'h0)
					rd_word = st.auxiliary_pointers[PADDR[4:2]];
				else
					rd_ok = 1'b0;
			end
		endcase
	end

	// ********************************************************
	// next state
	// ********************************************************
	always_comb
	begin
		nx = st;
		access = PSEL && PENABLE;
		new_kind = kind_of(PWDATA[15:0]);
		// normalize by register number names its pointer directly
		sel = (st.op[15:4] == 12'hff7) ? st.op[2:0] : st.pointer_select_reg;
		half = st.op[0] ? st.acc[15:0] : st.acc[31:16];
		half_res = half;
		wide_res = {st.acc, st.prod};
		acc_res = st.acc;
		ptr.cur = st.auxiliary_pointers[sel];
		ptr.ar0 = st.auxiliary_pointers[0];
		ptr.mode = pmode_of(st.op);
		nx.pready = 1'b0;

		case (st.fsm)
			nnao_pkg::NNAO_IDLE:
			begin
				// bus stalls while an operation runs: answers only in idle
				if (access && st.pready)
				begin
					if (PWRITE && rd_ok)
					begin
						case (PADDR)
							`NNAO_OFF_CMD:
							begin
								if (new_kind != nnao_pkg::NNAO_K_NONE)
								begin
									nx.op = PWDATA[15:0];
									nx.kind = new_kind;
									nx.fsm = nnao_pkg::NNAO_EXEC;
									nx.busy = 1'b1;
									if (new_kind == nnao_pkg::NNAO_K_NOP
										|| new_kind == nnao_pkg::NNAO_K_NORMALIZE_OP)
										nx.iter = st.repeat_count_reg;
									else
										nx.iter = '0;
									nx.repeat_count_reg = '0;
								end
							end
							`NNAO_OFF_ACC:  nx.acc = PWDATA;
							`NNAO_OFF_PROD: nx.prod = PWDATA;
							`NNAO_OFF_STAT:
							begin
								nx.n = PWDATA[`NNAO_ST_N];
								nx.z = PWDATA[`NNAO_ST_Z];
								nx.c = PWDATA[`NNAO_ST_C];
								nx.v = PWDATA[`NNAO_ST_V];
								nx.test_condition_flag = PWDATA[`NNAO_ST_TEST];
								nx.saturation_mode_bit = PWDATA[`NNAO_ST_SAT];
							end
							`NNAO_OFF_PSEL:
								nx.pointer_select_reg = PWDATA[2:0];
							`NNAO_OFF_RCNT:
								nx.repeat_count_reg = PWDATA[`NNAO_RCNT_W-1:0];
							default:
								nx.auxiliary_pointers[PADDR[4:2]] = PWDATA;
						endcase
					end
				end
				else if (access)
				begin
					nx.pready = 1'b1;
					nx.prdata = rd_ok ? rd_word : `NNAO_RST_WORD;
					nx.pslverr = !rd_ok;
				end
			end

			nnao_pkg::NNAO_EXEC:
			begin
				case (st.kind)
					nnao_pkg::NNAO_K_NEGH:
					begin
						// overflow only on most negative half
						if (half == `NNAO_MIN16)
						begin
							half_res = half;
							nx.v = 1'b1;
						end
						else
							half_res = -half;
						if (st.op[0])
							nx.acc[15:0] = half_res;
						else
							nx.acc[31:16] = half_res;
						nx.n = half_res[15];
						nx.z = (half_res == 16'h0000);
						nx.c = (half_res == 16'h0000);
					end

					nnao_pkg::NNAO_K_WIDENEG:
					begin
						if ({st.acc, st.prod} == `NNAO_MIN64)
						begin
							nx.v = 1'b1;
							wide_res = st.saturation_mode_bit ?
								`NNAO_MAX64 : `NNAO_MIN64;
						end
						else
							wide_res = -{st.acc, st.prod};
						nx.acc = wide_res[63:32];
						nx.prod = wide_res[31:0];
						nx.n = wide_res[63];
						nx.z = (wide_res == 64'h0);
						nx.c = (wide_res == 64'h0);
					end

					nnao_pkg::NNAO_K_CONDNEG:
					begin
						if (st.test_condition_flag)
						begin
							if (st.acc == `NNAO_MIN32)
							begin
								nx.v = 1'b1;
								acc_res = st.saturation_mode_bit ?
									`NNAO_MAX32 : `NNAO_MIN32;
							end
							else
								acc_res = -st.acc;
							nx.c = (acc_res == 32'h0);
						end
						nx.acc = acc_res;
						nx.n = acc_res[31];
						nx.z = (acc_res == 32'h0);
					end

					nnao_pkg::NNAO_K_NOP:
					begin
						nx.auxiliary_pointers[sel] = ptr.nxt;
						if (st.op[3])
							nx.pointer_select_reg = st.op[2:0];
					end

					nnao_pkg::NNAO_K_NORMALIZE_OP:
					begin
						// shift only on equal sign bits
						if (st.acc != 32'h0 && st.acc[31] == st.acc[30])
						begin
							acc_res = {st.acc[30:0], 1'b0};
							nx.auxiliary_pointers[sel] = ptr.nxt;
							nx.test_condition_flag = 1'b0;
						end
						else
							nx.test_condition_flag = 1'b1;
						nx.acc = acc_res;
						nx.n = acc_res[31];
						nx.z = (acc_res == 32'h0);
					end

					default:
					begin
						nx.fsm = nnao_pkg::NNAO_IDLE;
					end
				endcase

				// one iteration per cycle, last one leaves the flags
				if (st.iter == '0)
				begin
					if (st.kind == nnao_pkg::NNAO_K_NORMALIZE_OP)
					begin
						// three tail cycles give count plus four
						nx.fsm = nnao_pkg::NNAO_TAIL;
						nx.tail = `NNAO_NORMALIZE_OP_TAIL;
					end
					else
					begin
						nx.fsm = nnao_pkg::NNAO_IDLE;
						nx.busy = 1'b0;
					end
				end
				else
					nx.iter = st.iter - 1'b1;
			end

			nnao_pkg::NNAO_TAIL:
			begin
				if (st.tail == 2'h1)
				begin
					nx.fsm = nnao_pkg::NNAO_IDLE;
					nx.busy = 1'b0;
				end
				else
					nx.tail = st.tail - 1'b1;
			end

			default:
			begin
				nx.fsm = nnao_pkg::NNAO_IDLE;
				nx.busy = 1'b0;
			end
		endcase
	end

	// ********************************************************
	// registers
	// ********************************************************
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
			st <= '0;
		else if (CLK_EN)
			st <= nx;
	end

	assign PRDATA = st.prdata;
	assign PREADY = st.pready;
	assign PSLVERR = st.pslverr;
	assign BUSY = st.busy;

endmodule // nnao_top

`default_nettype wire

// ==== test/nnao_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none

module nnao_monitor
(
	// clock and reset
	input wire logic        REF_CLK,
	input wire logic        SYS_RST,
	input wire logic        CLK_EN,
	// apb
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	// status
	input wire logic        BUSY
);
	logic        cmd;
	logic [15:0] op;
	logic        is_idle;
	logic        is_normalize_op;
	logic [7:0]  shd;
	logic [8:0]  want;
	logic [8:0]  cnt;
	logic [1:0]  knd;

	assign cmd = PSEL & PENABLE & PREADY & PWRITE & CLK_EN & (PADDR == 8'h00);
	assign op = PWDATA[15:0];
	assign is_idle = (op[15:8] == 8'h77);
	assign is_normalize_op = (op == 16'h5624) | (op == 16'h565a) | (op == 16'h5620)
		| (op == 16'h5677) | (op == 16'h5630) | (op[15:4] == 12'hff7);

	// shadow repeat count, since busy length depends on it
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			shd <= 8'h00;
			want <= 9'h000;
			knd <= 2'h0;
			cnt <= 9'h000;
		end
		else if (CLK_EN)
		begin
			cnt <= BUSY ? cnt + 9'h001 : 9'h000;
			if (PSEL & PENABLE & PREADY & PWRITE & (PADDR == 8'h14))
				shd <= PWDATA[7:0];
			if (cmd)
			begin
				shd <= 8'h00;
				knd <= is_idle ? 2'h1 : (is_normalize_op ? 2'h2 : 2'h0);
				want <= {1'b0, shd} + (is_idle ? 9'h001 : 9'h004);
			end
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);

	chk_half_once: assert property (cmd && op[15:1] == 15'h7fae |=> BUSY ##1 !BUSY)
		else $error("half negate busy not one cycle");
	chk_wide_once: assert property (cmd && op == 16'h5658 |=> BUSY ##1 !BUSY)
		else $error("wide negate busy not one cycle");
	chk_cneg_once: assert property (cmd && op == 16'h5632 |=> BUSY ##1 !BUSY)
		else $error("conditional negate busy not one cycle");
	chk_idle_count: assert property (knd == 2'h1 && $fell(BUSY) |-> cnt == want)
		else $error("idle op busy length wrong");
	chk_normalize_op_count: assert property (knd == 2'h2 && $fell(BUSY) |-> cnt == want)
		else $error("normalize busy length wrong");
	chk_normalize_op_floor: assert property (cmd && is_normalize_op |=> BUSY [*4])
		else $error("normalize ended too soon");
	chk_idle_start: assert property (cmd && is_idle |=> BUSY)
		else $error("idle op did not start");
	chk_busy_quiet: assert property (BUSY |-> !PREADY)
		else $error("bus answered mid operation");
endmodule // nnao_monitor

bind nnao_top nnao_monitor u_mon (.REF_CLK, .SYS_RST, .CLK_EN, .PSEL, .PENABLE,
	.PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .BUSY);

`default_nettype wire

// ==== test/nnao_tb.sv ====
`timescale 1ns/1ns
`default_nettype none

module tb;
	logic        REF_CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic        BUSY, er;
	logic [7:0]  PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	int          num_errors = 0;
	int          num_checks = 0;
	int          cyc = 0;

	// clock enable tied: freezing is not exercised here
	nnao_top uut (.REF_CLK, .SYS_RST, .CLK_EN(1'b1), .PSEL, .PENABLE, .PWRITE,
		.PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .BUSY);

	initial
	begin
		REF_CLK = 1'b0;
		forever #4 REF_CLK = ~REF_CLK;
	end

	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge REF_CLK)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			num_errors++;
			$display("Error %0t: timeout", $time);
			give_verdict;
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("Error %0t: saw %h want %h", $time, s, e);
		end
	endtask

	// one apb transfer; holds everything until pready is sampled
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		do @(posedge REF_CLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	task automatic neg_case(input logic [15:0] op, input logic [31:0] a, p, s,
		ea, ep, es);
		apb(1'b1, 8'h04, a);
		apb(1'b1, 8'h08, p);
		apb(1'b1, 8'h0c, s);
		apb(1'b1, 8'h14, 32'h5);
		apb(1'b1, 8'h00, {16'h0, op});
		rc(8'h04, ea);
		rc(8'h08, ep);
		rc(8'h0c, es);
		rc(8'h14, 32'h0);
	endtask

	task automatic normalize_op_case(input logic [15:0] op, input logic [31:0] n, a,
		input logic [7:0] pa, input logic [31:0] p, ea, ep, es);
		apb(1'b1, 8'h04, a);
		apb(1'b1, pa, p);
		apb(1'b1, 8'h0c, 32'h0);
		apb(1'b1, 8'h14, n);
		apb(1'b1, 8'h00, {16'h0, op});
		rc(8'h04, ea);
		rc(pa, ep);
		rc(8'h0c, es);
	endtask

	task automatic t_reset;
		for (int a = 0; a <= 20; a += 4)
			rc(8'(a), 32'h0);
		apb(1'b1, 8'h18, 32'h5);
		apb(1'b0, 8'h18, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("test reset done");
	endtask

	task automatic t_half;
		neg_case(16'hff5c, 32'h8000, 0, 0, 32'h8000, 0, 32'h06);
		neg_case(16'hff5d, 32'h8000, 0, 0, 32'h8000, 0, 32'h09);
		neg_case(16'hff5c, 32'h12340001, 0, 8, 32'hedcc0001, 0, 9);
		neg_case(16'hff5d, 32'h1, 0, 8, 32'hffff, 0, 32'h09);
		$display("test half done");
	endtask

	task automatic t_wide;
		neg_case(16'h5658, 32'h80000000, 0, 32'h20, 32'h7fffffff,
			32'hffffffff, 32'h28);
		neg_case(16'h5658, 32'h80000000, 0, 0, 32'h80000000, 0, 9);
		neg_case(16'h5658, 1, 1, 8, 32'hfffffffe, 32'hffffffff, 9);
		neg_case(16'h5658, 0, 0, 0, 0, 0, 32'h06);
		$display("test wide done");
	endtask

	task automatic t_cneg;
		neg_case(16'h5632, 5, 0, 32'h04, 5, 0, 32'h04);
		neg_case(16'h5632, 32'h80000000, 0, 32'h30, 32'h7fffffff, 0,
			32'h38);
		neg_case(16'h5632, 32'h80000000, 0, 32'h10, 32'h80000000, 0,
			32'h19);
		neg_case(16'h5632, 0, 0, 32'h10, 0, 0, 32'h16);
		neg_case(16'h5632, 1, 0, 32'h14, 32'hffffffff, 0, 32'h11);
		$display("test cneg done");
	endtask

	task automatic t_idle;
		apb(1'b1, 8'h10, 32'h2);
		apb(1'b1, 8'h28, 32'h10);
		apb(1'b1, 8'h14, 32'h3);
		apb(1'b1, 8'h00, 32'h774a);
		rc(8'h28, 32'h14);
		apb(1'b1, 8'h00, 32'h7700);
		rc(8'h28, 32'h14);
		rc(8'h10, 32'h2);
		apb(1'b1, 8'h00, 32'h770b);
		rc(8'h10, 32'h3);
		// decrement form steps with the old select, then switches it
		apb(1'b1, 8'h00, 32'h778a);
		rc(8'h2c, 32'hffffffff);
		rc(8'h10, 32'h2);
		rc(8'h00, 32'h778a);
		$display("test idle done");
	endtask

	task automatic t_normalize_op;
		apb(1'b1, 8'h10, 32'h2);
		apb(1'b1, 8'h20, 32'h5);
		normalize_op_case(16'h565a, 31, 1, 8'h28, 0, 32'h40000000, 30, 32'h10);
		normalize_op_case(16'h5620, 0, '1, 8'h28, 30, 32'hfffffffe, 29, 1);
		normalize_op_case(16'h5677, 0, 32'h20000000, 8'h28, 29, 32'h40000000, 34,
			0);
		normalize_op_case(16'h5630, 0, 32'h20000000, 8'h28, 34, 32'h40000000, 29,
			0);
		normalize_op_case(16'h5624, 0, 32'h20000000, 8'h28, 29, 32'h40000000, 29,
			0);
		normalize_op_case(16'h565a, 0, 32'h40000000, 8'h28, 29, 32'h40000000, 29,
			32'h10);
		normalize_op_case(16'hff7b, 0, 1, 8'h2c, 7, 2, 8, 0);
		normalize_op_case(16'hff7b, 0, 0, 8'h2c, 7, 0, 7, 32'h12);
		normalize_op_case(16'hff73, 0, 32'hc0000000, 8'h2c, 7, 32'h80000000, 6,
			1);
		$display("test normalize_op done");
	endtask

	initial
	begin
		SYS_RST = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		repeat (6) @(posedge REF_CLK);
		SYS_RST <= 1'b0;
		t_reset;
		t_half;
		t_wide;
		t_cneg;
		t_idle;
		t_normalize_op;
		give_verdict;
	end
endmodule // tb

`default_nettype wire
